// ==== common/arith_pkg.sv ====
// package: constants, field layout, register map and sequencer states of the arithmetic unit
`default_nettype none
package arith_pkg;
  // word layout: sign on top, six excess-three digits or 24 binary bits below
  localparam int WORD_W = 25;
  localparam int SIGN_BIT = 24;
  localparam int ADDR_W = 15;

  // instruction word positions (bit 25 of the word sits at index 24)
  localparam int IA_BIT = 24;
  localparam int IX_LSB = 20;
  localparam int OP_LSB = 14;
  localparam int FLD_LSB = 10;
  localparam int M_LSB = 0;

  // operation codes, printed in octal
  localparam logic [5:0] OP_DEC_SUB = 6'h11;    // 21 octal
  localparam logic [5:0] OP_DEC_ADD_UP = 6'h12; // 22 octal
  localparam logic [5:0] OP_DEC_SUB_UP = 6'h13; // 23 octal
  localparam logic [5:0] OP_BIN_ADD = 6'h14;    // 24 octal
  localparam logic [5:0] OP_BIN_SUB = 6'h15;    // 25 octal
  localparam logic [5:0] OP_BIN_ADD_UP = 6'h16; // 26 octal
  localparam logic [5:0] OP_DEC_MUL = 6'h18;    // 30 octal
  localparam logic [5:0] OP_DEC_DIV = 6'h19;    // 31 octal

  // register field codes and digit codes
  localparam logic [3:0] FIELD_MULTI = 4'hF;
  localparam logic [3:0] DIGIT_BIN_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_X3_ZERO = 4'h3;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // register port map
  localparam logic [4:0] REG_AR1 = 5'h00;
  localparam logic [4:0] REG_AR2 = 5'h01;
  localparam logic [4:0] REG_AR4 = 5'h02;
  localparam logic [4:0] REG_AR8 = 5'h03;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_INDEX_BASE = 5'h10;
  localparam int STAT_ZERO = 0;
  localparam int STAT_OVF = 1;
  localparam int STAT_BUSY = 2;

  // reset values
  localparam logic [24:0] ACC_RESET = 25'h0000000;
  localparam logic [14:0] INDEX_RESET = 15'h0000;

  // execution lengths in clock cycles, counted from the start of the accepting cycle
  localparam logic [5:0] ADD_CYCLES = 6'h02;
  localparam logic [5:0] MUL_MIN_CYCLES = 6'h0C;
  localparam logic [5:0] MUL_MAX_CYCLES = 6'h1F;
  localparam logic [5:0] DIV_MIN_CYCLES = 6'h11;
  localparam logic [5:0] DIV_MAX_CYCLES = 6'h24;
  localparam logic [5:0] DIGIT_SUM_MAX = 6'h36;

  // sequencer, gray coded along idle, fetch, fetch high, wait
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_FETCH_HI = 2'b11,
    SEQ_WAIT = 2'b10
  } seq_state_t;
endpackage
`default_nettype wire

// ==== hw/decimal_binary_arith_unit.sv ====
// design: decimal and binary arithmetic unit with accumulators, index registers and register port
//
// What this block does
// - primary operand comes from the accumulators named by the weighted register field
// - add and subtract set the zero flag on zero result, clear otherwise
// - effective address is operand address plus the named index register
// - opcode 22 adds memory to higher register, sum into lower named register
// - the source registers of one-word and decimal to-higher additions stay unchanged
// - decimal addition treats a 0000 digit as excess-three zero 0011
// - decimal subtraction treats a 0000 digit as excess-three zero 0011
// - multi-word decimal add-to-higher uses pair 12, sum in pair 3
// - opcode 21 subtracts memory from the register in two cycles
// - opcode 23 subtracts memory from source into the other register
// - multi-word decimal subtract-to-higher uses pair 12, result in pair 3
// - opcode 30 multiplies by register eight, product in four and two
// - multiply field is 1110; multiplier and multiplicand stay unchanged
// - opcode 31 divides pair twelve, quotient in four, remainder in eight
// - divisor not above register eight sets overflow and raises contingency
// - remainder takes the dividend sign
// - opcode 24 adds memory in binary to the register in two cycles
// - opcode 26 adds memory in binary, sum into the other register
// - multi-word binary add-to-higher uses pair 12, sum in register 4
// - opcode 25 subtracts memory in binary from the register in two cycles
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module decimal_binary_arith_unit (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic [24:0] instrWord,
  output logic busy,
  output logic done,
  output logic memRead,
  output logic [14:0] memAddr,
  input wire logic [24:0] memData,
  input wire logic [4:0] regAddr,
  input wire logic [24:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [24:0] regRdData,
  output logic zeroResultFlag,
  output logic overflowFlag,
  output logic contingencyIrq
);

  arith_pkg::seq_state_t state_r;
  logic [24:0] acc_r [4];
  logic [14:0] idxR [16];
  logic [24:0] instrR;
  logic [14:0] eaR;
  logic [24:0] memLoR;
  logic [24:0] pendVal_r [4];
  logic [3:0] pendMask_r;
  logic [5:0] waitCnt_r;
  logic zeroFlag_r;
  logic ovfFlag_r;
  logic irq_r;
  logic [24:0] rdData_r;

  // effective address: index zero means no indexing
  function automatic logic [14:0] effAddr(input logic [9:0] m, input logic [14:0] idx);
    return {5'h00, m} + idx;
  endfunction

  // one digit to its value; binary zero counts as excess-three zero, 0001 and 0010 read as zero, junk above twelve clamps to nine
  function automatic logic [3:0] digitVal(input logic [3:0] d);
    logic [3:0] f;
    f = (d == arith_pkg::DIGIT_BIN_ZERO) ? arith_pkg::DIGIT_X3_ZERO : d;
    if (f < arith_pkg::DIGIT_X3_ZERO)
      return 4'h0;
    if (f - arith_pkg::DIGIT_X3_ZERO > arith_pkg::DIGIT_MAX)
      return arith_pkg::DIGIT_MAX;
    return f - arith_pkg::DIGIT_X3_ZERO;
  endfunction

  // twelve excess-three digits to binary
  function automatic logic [39:0] dec2bin(input logic [47:0] w);
    logic [39:0] acc;
    acc = 40'h0;
    for (int i = 11; i >= 0; i--)
      acc = acc * 40'hA + {36'h0, digitVal(w[i*4 +: 4])};
    return acc;
  endfunction

  // binary to twelve excess-three digits; anything above twelve digits is lost
  function automatic logic [47:0] bin2dec(input logic [39:0] v);
    logic [39:0] rest;
    logic [39:0] rem;
    logic [47:0] res;
    rest = v;
    res = 48'h0;
    for (int i = 0; i < 12; i++)
    begin
      rem = rest % 40'hA;
      res[i*4 +: 4] = rem[3:0] + arith_pkg::DIGIT_X3_ZERO;
      rest = rest / 40'hA;
    end
    return res;
  endfunction

  // sum of the six digit values of one word
  function automatic logic [5:0] digitSum(input logic [23:0] w);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 6; i++)
      s = s + {2'b00, digitVal(w[i*4 +: 4])};
    return s;
  endfunction

  // data-dependent length: the minimum plus a share of the span scaled by the digit sum
  function automatic logic [5:0] opCycles(input logic [5:0] lo, input logic [5:0] hi,
                                          input logic [5:0] sum);
    logic [10:0] extra;
    extra = ({5'h00, sum} * {5'h00, hi - lo}) / {5'h00, arith_pkg::DIGIT_SUM_MAX};
    return lo + extra[5:0];
  endfunction

  // sign-magnitude addition; a subtract arrives with the second sign already flipped
  function automatic logic [48:0] smAdd(input logic sa, input logic [47:0] a,
                                        input logic sb, input logic [47:0] b);
    if (sa == sb)
      return {sa, a + b};
    if (a >= b)
      return {sa, a - b};
    return {sb, b - a};
  endfunction

  // highest and lowest register named by the weighted field (8, 4, 2, 1)
  function automatic logic [1:0] topBit(input logic [3:0] f);
    return f[3] ? 2'd3 : f[2] ? 2'd2 : f[1] ? 2'd1 : 2'd0;
  endfunction
  function automatic logic [1:0] lowBit(input logic [3:0] f);
    return f[0] ? 2'd0 : f[1] ? 2'd1 : f[2] ? 2'd2 : 2'd3;
  endfunction

  function automatic logic opKnown(input logic [5:0] op);
    return op inside {arith_pkg::OP_DEC_SUB, arith_pkg::OP_DEC_ADD_UP, arith_pkg::OP_DEC_SUB_UP,
                      arith_pkg::OP_BIN_ADD, arith_pkg::OP_BIN_SUB, arith_pkg::OP_BIN_ADD_UP,
                      arith_pkg::OP_DEC_MUL, arith_pkg::OP_DEC_DIV};
  endfunction

  // decode of the latched instruction
  logic [5:0] opc;
  logic [3:0] fld;
  logic isUpper, isDecimal, isSub, isMul, isDiv, wide;
  assign opc = instrR[arith_pkg::OP_LSB +: 6];
  assign fld = instrR[arith_pkg::FLD_LSB +: 4];
  assign isUpper = opc inside {arith_pkg::OP_DEC_ADD_UP, arith_pkg::OP_DEC_SUB_UP,
                               arith_pkg::OP_BIN_ADD_UP};
  assign isDecimal = opc inside {arith_pkg::OP_DEC_SUB, arith_pkg::OP_DEC_ADD_UP,
                                 arith_pkg::OP_DEC_SUB_UP};
  assign isSub = opc inside {arith_pkg::OP_DEC_SUB, arith_pkg::OP_DEC_SUB_UP,
                             arith_pkg::OP_BIN_SUB};
  assign isMul = (opc == arith_pkg::OP_DEC_MUL);
  assign isDiv = (opc == arith_pkg::OP_DEC_DIV);
  // multiply and divide are always single word, whatever the field holds
  assign wide = !(isMul || isDiv) &&
                (isUpper ? (fld == arith_pkg::FIELD_MULTI) : (topBit(fld) != lowBit(fld)));

  // handshake
  logic accept, dataCycle, needWait, commitNow, commitWait;
  assign busy = (state_r != arith_pkg::SEQ_IDLE);
  assign accept = !busy && instrValid && opKnown(instrWord[arith_pkg::OP_LSB +: 6]);
  assign dataCycle = (state_r == arith_pkg::SEQ_FETCH && !wide) ||
                     (state_r == arith_pkg::SEQ_FETCH_HI);

  // operand fetch: low word at the effective address, high word one below it
  assign memRead = accept || (state_r == arith_pkg::SEQ_FETCH && wide);
  assign memAddr = busy ? eaR - 15'h0001 :
                   effAddr(instrWord[arith_pkg::M_LSB +: 10],
                           idxR[instrWord[arith_pkg::IX_LSB +: 4]]);

  // result calculation, valid in the data cycle
  logic [24:0] calcVal [4];
  logic [3:0] calcMask;
  logic calcZero, calcFlagUpd, calcOvf;
  logic [5:0] calcCycles;
  always_comb
  begin
    logic [1:0] srcHi, srcLo, dstHi, dstLo;
    logic [47:0] priMag, secMag, resMag, opA, opB;
    logic [48:0] sum;
    logic [39:0] prod, dvd, dvs, hiVal, quot, rem;
    logic [47:0] prodDec, quotDec, remDec;
    logic priSign, secSign;
    srcHi = 2'd0;
    srcLo = 2'd0;
    dstHi = 2'd0;
    dstLo = 2'd0;
    for (int i = 0; i < 4; i++)
      calcVal[i] = acc_r[i];
    calcMask = 4'h0;
    calcZero = 1'b0;
    calcFlagUpd = 1'b0;
    calcOvf = 1'b0;
    calcCycles = arith_pkg::ADD_CYCLES;
    // source pair: field 1111 on a to-higher op means pair 12 (registers eight and four)
    srcHi = (isUpper && wide) ? 2'd3 : topBit(fld);
    srcLo = (isUpper && wide) ? 2'd2 : lowBit(fld);
    priMag = wide ? {acc_r[srcHi][23:0], acc_r[srcLo][23:0]} : {24'h0, acc_r[srcHi][23:0]};
    priSign = acc_r[srcHi][arith_pkg::SIGN_BIT];
    secMag = wide ? {memData[23:0], memLoR[23:0]} : {24'h0, memData[23:0]};
    secSign = memData[arith_pkg::SIGN_BIT];
    // destination: same registers, the lower one named for one-word to-higher ops, pair 3 (decimal) or register four (binary) for wide ones
    if (!isUpper)
    begin
      dstHi = srcHi;
      dstLo = srcLo;
    end
    else if (!wide)
    begin
      dstHi = lowBit(fld);
      dstLo = lowBit(fld);
    end
    else if (isDecimal)
    begin
      dstHi = 2'd1;
      dstLo = 2'd0;
    end
    else
    begin
      dstHi = 2'd2;
      dstLo = 2'd2;
    end
    opA = isDecimal ? {8'h00, dec2bin(priMag)} : priMag;
    opB = isDecimal ? {8'h00, dec2bin(secMag)} : secMag;
    sum = smAdd(priSign, opA, secSign ^ isSub, opB);
    resMag = isDecimal ? bin2dec(sum[39:0]) : sum[47:0];
    // decimal multiply: digits are taken as excess-three already
    prod = dec2bin({24'h0, acc_r[3][23:0]}) *
           dec2bin({24'h0, memData[23:0]});
    prodDec = bin2dec(prod);
    // decimal divide: dividend is register eight over register four
    dvd = dec2bin({acc_r[3][23:0], acc_r[2][23:0]});
    dvs = dec2bin({24'h0, memData[23:0]});
    hiVal = dec2bin({24'h0, acc_r[3][23:0]});
    calcOvf = isDiv && (dvs <= hiVal);
    // a zero divisor always overflows, so the guard only keeps simulation clean
    quot = dvd / (calcOvf ? 40'h1 : dvs);
    rem = dvd % (calcOvf ? 40'h1 : dvs);
    quotDec = bin2dec(quot);
    remDec = bin2dec(rem);
    if (isMul)
    begin
      // multiplier in register eight and the memory word are only read
      calcVal[2] = {acc_r[3][24] ^ memData[24], prodDec[47:24]};
      calcVal[1] = {acc_r[3][24] ^ memData[24], prodDec[23:0]};
      calcMask = 4'b0110;
      calcCycles = opCycles(arith_pkg::MUL_MIN_CYCLES, arith_pkg::MUL_MAX_CYCLES,
                            digitSum(acc_r[3][23:0]));
    end
    else if (isDiv)
    begin
      calcVal[2] = {acc_r[3][24] ^ memData[24], quotDec[23:0]};
      calcVal[3] = {acc_r[3][24], remDec[23:0]};
      calcMask = calcOvf ? 4'b0000 : 4'b1100;
      calcCycles = opCycles(arith_pkg::DIV_MIN_CYCLES, arith_pkg::DIV_MAX_CYCLES,
                            digitSum(quotDec[23:0]));
    end
    else
    begin
      // only destination bits are set, so a to-higher source keeps its value, except register four in the wide binary form
      calcVal[dstLo] = {sum[48], resMag[23:0]};
      calcMask[dstLo] = 1'b1;
      if (dstHi != dstLo)
      begin
        calcVal[dstHi] = {sum[48], resMag[47:24]};
        calcMask[dstHi] = 1'b1;
      end
      calcZero = (sum[47:0] == 48'h0);
      calcFlagUpd = 1'b1;
    end
  end

  // long operations park their result until the count runs out
  assign needWait = (isMul || isDiv) && !calcOvf;
  assign commitNow = dataCycle && !needWait;
  assign commitWait = (state_r == arith_pkg::SEQ_WAIT) && (waitCnt_r == 6'h01);
  assign done = commitNow || commitWait;

  // sequencer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_r <= arith_pkg::SEQ_IDLE;
    else
      unique case (state_r)
        arith_pkg::SEQ_IDLE:
          if (accept)
            state_r <= arith_pkg::SEQ_FETCH;
        arith_pkg::SEQ_FETCH:
          if (wide)
            state_r <= arith_pkg::SEQ_FETCH_HI;
          else if (needWait)
            state_r <= arith_pkg::SEQ_WAIT;
          else
            state_r <= arith_pkg::SEQ_IDLE;
        arith_pkg::SEQ_FETCH_HI:
          state_r <= arith_pkg::SEQ_IDLE;
        arith_pkg::SEQ_WAIT:
          if (waitCnt_r == 6'h01)
            state_r <= arith_pkg::SEQ_IDLE;
      endcase
  end

  // instruction, effective address and low operand word capture
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      instrR <= 25'h0000000;
      eaR <= arith_pkg::INDEX_RESET;
      memLoR <= 25'h0000000;
    end
    else
    begin
      if (accept)
      begin
        instrR <= instrWord;
        eaR <= memAddr;
      end
      if (state_r == arith_pkg::SEQ_FETCH && wide)
        memLoR <= memData;
    end
  end

  // cycle count and parked result; two cycles are already spent by the accepting cycle and the data cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      waitCnt_r <= 6'h00;
      pendMask_r <= 4'h0;
      for (int i = 0; i < 4; i++)
        pendVal_r[i] <= arith_pkg::ACC_RESET;
    end
    else if (dataCycle && needWait)
    begin
      waitCnt_r <= calcCycles - arith_pkg::ADD_CYCLES;
      pendMask_r <= calcMask;
      for (int i = 0; i < 4; i++)
        pendVal_r[i] <= calcVal[i];
    end
    else if (state_r == arith_pkg::SEQ_WAIT)
      waitCnt_r <= waitCnt_r - 6'h01;
  end

  // accumulators: results win; software writes are refused while busy
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      for (int i = 0; i < 4; i++)
        acc_r[i] <= arith_pkg::ACC_RESET;
    else if (commitNow || commitWait)
    begin
      for (int i = 0; i < 4; i++)
        if (commitNow ? calcMask[i] : pendMask_r[i])
          acc_r[i] <= commitNow ? calcVal[i] : pendVal_r[i];
    end
    else if (regWr && !busy && regAddr <= arith_pkg::REG_AR8)
      acc_r[regAddr[1:0]] <= regWrData;
  end

  // index registers; entry zero is hard zero so index 0 means unindexed
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      for (int i = 0; i < 16; i++)
        idxR[i] <= arith_pkg::INDEX_RESET;
    else if (regWr && regAddr[4] && regAddr[3:0] != 4'h0)
      idxR[regAddr[3:0]] <= regWrData[14:0];
  end

  // flags: overflow is sticky and cleared by writing one; a new overflow wins the clash
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      zeroFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (commitNow && calcFlagUpd)
        zeroFlag_r <= calcZero;
      if (dataCycle && calcOvf)
        ovfFlag_r <= 1'b1;
      else if (regWr && regAddr == arith_pkg::REG_STATUS && regWrData[arith_pkg::STAT_OVF])
        ovfFlag_r <= 1'b0;
      irq_r <= dataCycle && calcOvf;
    end
  end

  // register read, data one cycle after the strobe, unmapped reads as zero
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdData_r <= 25'h0000000;
    else if (regRd)
    begin
      if (regAddr <= arith_pkg::REG_AR8)
        rdData_r <= acc_r[regAddr[1:0]];
      else if (regAddr == arith_pkg::REG_STATUS)
        rdData_r <= {22'h0, busy, ovfFlag_r, zeroFlag_r};
      else if (regAddr[4])
        rdData_r <= {10'h000, idxR[regAddr[3:0]]};
      else
        rdData_r <= 25'h0000000;
    end
  end

  assign regRdData = rdData_r;
  assign zeroResultFlag = zeroFlag_r;
  assign overflowFlag = ovfFlag_r;
  assign contingencyIrq = irq_r;

endmodule // decimal_binary_arith_unit
`default_nettype wire

// ==== bench/decimal_binary_arith_unit_asserts.sv ====
// checker: port timing of the arithmetic unit
`timescale 1ns/100ps
`default_nettype none
module decimal_binary_arith_unit_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic [24:0] instrWord,
  input wire logic busy,
  input wire logic done,
  input wire logic memRead,
  input wire logic [14:0] memAddr,
  input wire logic overflowFlag,
  input wire logic contingencyIrq
);
  logic [5:0] opc;
  logic addSub;
  logic take;
  logic oneWord;
  // a request counts only when idle and its code is served here
  assign opc = instrWord[19:14];
  assign addSub = opc inside {arith_pkg::OP_DEC_SUB, arith_pkg::OP_DEC_ADD_UP,
    arith_pkg::OP_DEC_SUB_UP, arith_pkg::OP_BIN_ADD, arith_pkg::OP_BIN_SUB,
    arith_pkg::OP_BIN_ADD_UP};
  assign take = instrValid && !busy && (addSub || opc == arith_pkg::OP_DEC_MUL
    || opc == arith_pkg::OP_DEC_DIV);
  // code bit 1 marks the to-higher forms, which name two registers for one word
  assign oneWord = opc[1] ? ($countones(instrWord[13:10]) == 2) : $onehot(instrWord[13:10]);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_add_len;
    take && addSub && oneWord |-> ##1 done;
  endproperty
  a_add_len: assert property (p_add_len)
    else $error("one-word add or subtract not done in two cycles");
  property p_read_take;
    take |-> memRead;
  endproperty
  a_read_take: assert property (p_read_take)
    else $error("operand read missing at acceptance");
  property p_addr_direct;
    take && instrWord[23:20] == 4'h0 |-> memAddr == {5'h00, instrWord[9:0]};
  endproperty
  a_addr_direct: assert property (p_addr_direct)
    else $error("unindexed address wrong");
  property p_busy_take;
    take |=> busy;
  endproperty
  a_busy_take: assert property (p_busy_take)
    else $error("busy not raised after acceptance");
  property p_done_end;
    done |=> !busy && !done;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy or done lingers after completion");
  property p_mul_len;
    take && opc == arith_pkg::OP_DEC_MUL |-> ##1 (!done)[*8] ##[3:22] done;
  endproperty
  a_mul_len: assert property (p_mul_len)
    else $error("multiply length outside 12 to 31 cycles");
  property p_div_len;
    take && opc == arith_pkg::OP_DEC_DIV |-> ##[1:35] done;
  endproperty
  a_div_len: assert property (p_div_len)
    else $error("divide did not finish in time");
  property p_ovf_cause;
    $rose(overflowFlag) |-> $past(done) && contingencyIrq;
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow set without divide completion and interrupt");
  property p_irq_pulse;
    contingencyIrq |-> overflowFlag ##1 !contingencyIrq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt not a single pulse with overflow");
  property p_no_stray;
    !busy && !take |-> !memRead && !done;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("read or done while idle");
  c_add: cover property (take && addSub && oneWord);
  c_mul: cover property (take && opc == arith_pkg::OP_DEC_MUL);
  c_irq: cover property (contingencyIrq);
endmodule // decimal_binary_arith_unit_asserts
bind decimal_binary_arith_unit decimal_binary_arith_unit_asserts
  i_decimal_binary_arith_unit_asserts (
  .clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
  .busy(busy), .done(done), .memRead(memRead), .memAddr(memAddr),
  .overflowFlag(overflowFlag), .contingencyIrq(contingencyIrq));
`default_nettype wire

// ==== bench/decimal_binary_arith_unit_tb.sv ====
// testbench: random and corner instructions checked against reckoned results
`timescale 1ns/100ps
`default_nettype none
module decimal_binary_arith_unit_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid = 1'b0;
  logic [24:0] instrWord = 25'h0000000;
  logic [24:0] memData = 25'h0000000;
  logic [4:0] regAddr = 5'h00;
  logic [24:0] regWrData = 25'h0000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic busy, done, memRead, zeroResultFlag, overflowFlag, contingencyIrq;
  logic [14:0] memAddr;
  logic [24:0] regRdData, rd;
  logic [23:0] a, b, r;
  logic [5:0] op;
  logic [3:0] x;
  logic [14:0] idx;
  logic up, dec, sub, zexp;
  longint vr, q;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int lat, sw, dw, sh;
  logic [5:0] ops [6] = '{arith_pkg::OP_DEC_SUB, arith_pkg::OP_DEC_ADD_UP,
    arith_pkg::OP_DEC_SUB_UP, arith_pkg::OP_BIN_ADD, arith_pkg::OP_BIN_SUB,
    arith_pkg::OP_BIN_ADD_UP};

  decimal_binary_arith_unit i_decimal_binary_arith_unit (.clk(clk), .reset_n(reset_n),
    .instrValid(instrValid), .instrWord(instrWord), .busy(busy), .done(done),
    .memRead(memRead), .memAddr(memAddr), .memData(memData), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .zeroResultFlag(zeroResultFlag), .overflowFlag(overflowFlag),
    .contingencyIrq(contingencyIrq));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(string name, logic [24:0] seen, logic [24:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // excess-three word to value; a 0000 digit reads as zero, digits clamp at nine
  function automatic longint dv(logic [23:0] w);
    longint v;
    int d;
    v = 0;
    for (int i = 5; i >= 0; i--)
    begin
      d = (w[4*i+:4] == 4'h0) ? 3 : int'(w[4*i+:4]);
      v = v * 10 + ((d - 3 > 9) ? 9 : d - 3);
    end
    return v;
  endfunction

  // value to six excess-three digits, higher digits dropped
  function automatic logic [23:0] de(longint v);
    logic [23:0] w;
    for (int i = 0; i < 6; i++)
    begin
      w[4*i+:4] = 4'(v % 10 + 3);
      v = v / 10;
    end
    return w;
  endfunction

  function automatic int dsum(longint v);
    int s;
    s = 0;
    for (int i = 0; i < 6; i++)
    begin
      s += int'(v % 10);
      v = v / 10;
    end
    return s;
  endfunction

  function automatic logic [4:0] ra(int w);
    return w == 8 ? arith_pkg::REG_AR8 : w == 4 ? arith_pkg::REG_AR4 :
      w == 2 ? arith_pkg::REG_AR2 : arith_pkg::REG_AR1;
  endfunction

  task automatic wr(logic [4:0] ad, logic [24:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rdr(logic [4:0] ad);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask

  // one instruction; memory data change once their cycle is over
  task automatic run(logic [5:0] o, logic [3:0] f, logic [9:0] m, logic [23:0] d, int expLat);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= {1'b0, x, o, f, m};
    memData <= {1'b0, d};
    #1 check("memAddr", {10'h000, memAddr}, {10'h000, 15'(m) + idx});
    @(posedge clk);
    instrValid <= 1'b0;
    lat = 1;
    #1;
    while (done !== 1'b1 && lat < 60)
    begin
      @(posedge clk);
      memData <= {1'b1, ~d};
      #1 lat++;
    end
    check("cycles", 25'(lat), 25'(expLat));
    @(posedge clk);
    memData <= {1'b1, ~d};
  endtask

  // main sequence
  initial
  begin
    void'($urandom(96289));
    x = 4'h0;
    idx = 15'h0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rdr(5'(i));
      check("resetValue", rd, 25'h0000000);
    end
    rdr(5'h08);
    check("unmapped", rd, 25'h0000000);
    // add and subtract forms with random pairs, equal and zero-digit corners
    for (int i = 0; i < 36; i++)
    begin
      op = ops[i % 6];
      up = op[1];
      dec = (i % 6) < 3;
      sub = (i % 2) == 0;
      sh = $urandom_range(0, up ? 2 : 3);
      sw = 8 >> sh;
      dw = up ? sw >> $urandom_range(1, 3 - sh) : sw;
      x = 4'($urandom_range(1, 15));
      idx = 15'($urandom_range(0, 500));
      wr(arith_pkg::REG_INDEX_BASE + {1'b0, x}, {10'h000, idx});
      for (int k = 0; k < 6; k++)
      begin
        a[4*k+:4] = dec ? 4'($urandom_range(3, 12)) : 4'($urandom);
        b[4*k+:4] = dec ? 4'($urandom_range(3, 12)) : 4'($urandom);
      end
      if (!dec)
        {a[23], b[23]} = 2'b00;
      if (i % 4 == 0)
        b = a;
      if (i % 4 == 1 && dec)
        b = 24'h000000;
      if (sub && (dec ? dv(a) < dv(b) : a < b))
        {a, b} = {b, a};
      vr = dec ? (sub ? dv(a) - dv(b) : dv(a) + dv(b)) : (sub ? a - b : a + b);
      r = dec ? de(vr) : 24'(vr);
      zexp = (vr == 0);
      wr(ra(sw), {1'b0, a});
      run(op, 4'(sw | dw), 10'($urandom), b, 1);
      rdr(ra(dw));
      check("result", rd, {1'b0, r});
      rdr(ra(sw));
      check("source", rd, up ? {1'b0, a} : {1'b0, r});
      check("zeroFlag", {24'h0, zeroResultFlag}, {24'h0, zexp});
    end
    x = 4'h0;
    idx = 15'h0000;
    // multiply, the last with all nines for the longest run
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 2) ? 24'hCCCCCC : de($urandom_range(1, 999999));
      b = de($urandom_range(1, 999999));
      wr(arith_pkg::REG_AR8, {1'b0, a});
      run(arith_pkg::OP_DEC_MUL, 4'hE, 10'h155, b, 11 + dsum(dv(a)) * 19 / 54);
      vr = dv(a) * dv(b);
      rdr(arith_pkg::REG_AR4);
      check("productHigh", rd, {1'b0, de(vr / 1000000)});
      rdr(arith_pkg::REG_AR2);
      check("productLow", rd, {1'b0, de(vr % 1000000)});
      rdr(arith_pkg::REG_AR8);
      check("multiplier", rd, {1'b0, a});
    end
    // divide, first with the smallest divisor that still fits
    for (int k = 0; k < 2; k++)
    begin
      a = de($urandom_range(0, 999));
      b = de(dv(a) + 1 + (k == 0 ? 0 : $urandom_range(0, 99999)));
      r = de($urandom_range(0, 999999));
      wr(arith_pkg::REG_AR8, {1'b0, a});
      wr(arith_pkg::REG_AR4, {1'b0, r});
      vr = dv(a) * 1000000 + dv(r);
      q = vr / dv(b);
      run(arith_pkg::OP_DEC_DIV, 4'hC, 10'h2A5, b, 16 + dsum(q) * 19 / 54);
      rdr(arith_pkg::REG_AR4);
      check("quotient", rd, {1'b0, de(q)});
      rdr(arith_pkg::REG_AR8);
      check("remainder", rd, {1'b0, de(vr % dv(b))});
    end
    // divisor equal to the high dividend word overflows
    wr(arith_pkg::REG_AR8, {1'b0, de(500)});
    run(arith_pkg::OP_DEC_DIV, 4'hC, 10'h011, de(500), 1);
    #1 check("overflow", {23'h0, overflowFlag, contingencyIrq}, 25'h0000003);
    @(posedge clk);
    #1 check("irqPulse", {24'h0, contingencyIrq}, 25'h0000000);
    rdr(arith_pkg::REG_AR8);
    check("noWrite", rd, {1'b0, de(500)});
    wr(arith_pkg::REG_STATUS, 25'h0000002);
    #1 check("ovfClear", {24'h0, overflowFlag}, 25'h0000000);
    // an unserved code is ignored
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= {5'h00, 6'h10, 4'h8, 10'h001};
    @(posedge clk);
    instrValid <= 1'b0;
    #1 check("ignored", {24'h0, busy}, 25'h0000000);
    test_done();
  end
endmodule // decimal_binary_arith_unit_tb
`default_nettype wire
